// file: logic/csc_pkg.sv
package csc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [31:0] CLOCK_CONTROL_ADDR = 32'h5000_0014;
    localparam logic [31:0] TIMER_CLOCK_PAD_MAP_ADDR = 32'h5000_0018;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SYS_SEL_LSB = 0;
    localparam int LP_SEL_LSB = 2;
    localparam int XTAL_DIS_BIT = 5;
    localparam int RUN_LP_BIT = 12;
    localparam int RUN_RC_BIT = 13;
    localparam int RUN_XTAL_BIT = 14;
    localparam int RUN_DBL_BIT = 15;
    localparam int WAKEUP_EN_BIT = 0;
    localparam int TMR1_HOLD_BIT = 1;
    localparam int TMR2_HOLD_BIT = 2;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0] SYS_FAST_CRYSTAL = 2'h0;
    localparam logic [1:0] SYS_FAST_RC = 2'h1;
    localparam logic [1:0] SYS_RC_LOWPOWER = 2'h2;
    localparam logic [1:0] SYS_DOUBLED = 2'h3;
    localparam logic [1:0] LP_RC_LOWPOWER = 2'h0;
    localparam logic [1:0] LP_RC_EXTENDED = 2'h1;
    localparam logic [1:0] LP_SLOW_CRYSTAL = 2'h2;
    localparam logic [1:0] LP_SQUARE_WAVE = 2'h3;
    localparam logic [1:0] SYS_SEL_RESET = SYS_FAST_RC;
    localparam logic [1:0] LP_SEL_RESET = LP_RC_LOWPOWER;

    // ************************************************************
    // Switch timing: gate-off and gate-on dwell, one less than the clock cycles spent in each
    // ************************************************************
    localparam logic [2:0] SWITCH_DWELL = 3'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } csc_bus_req_t;

    typedef struct packed {
        logic run_doubled;
        logic run_crystal;
        logic run_fast_rc;
        logic run_lowpower;
    } csc_running_t;

endpackage

// file: logic/csc_clock_source_select_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module csc_clock_source_select_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire csc_pkg::csc_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // Oscillator status
    input wire logic crystal_settled,
    input wire logic crystal_trim_ready,
    input wire logic wakeup_event,
    // Oscillator and mux control
    output logic fast_crystal_osc_enable,
    output logic [1:0] system_clock_select,
    output logic [1:0] lowpower_clock_select,
    output logic system_clock_gate,
    output logic [3:0] running_sources,
    // Always-on pad control
    output logic timer1_pwm_pad_hold,
    output logic timer2_pwm_pad_hold,
    output logic wakeup_counter_clock_enable
);

    // ************************************************************
    // Registers
    // ************************************************************
    typedef enum logic [1:0] {CSC_IDLE, CSC_GATE_OFF, CSC_GATE_ON} csc_state_t;

    csc_state_t state_reg;
    logic [1:0] sys_sel_reg;
    logic [1:0] active_sel_reg;
    logic [1:0] lp_sel_reg;
    logic crystal_disable_reg;
    logic [2:0] dwell_reg;
    logic [2:0] hold_reg;
    logic wr_ctrl;
    logic wr_tmr;

    function automatic logic [3:0] csc_onehot(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        case (sel)
            csc_pkg::SYS_FAST_CRYSTAL: r[2] = 1'b1;
            csc_pkg::SYS_FAST_RC: r[1] = 1'b1;
            csc_pkg::SYS_RC_LOWPOWER: r[0] = 1'b1;
            default: r[3] = 1'b1;
        endcase
        return r;
    endfunction

    assign wr_ctrl = bus_req.wr && (bus_req.addr == csc_pkg::CLOCK_CONTROL_ADDR);
    assign wr_tmr = bus_req.wr && (bus_req.addr == csc_pkg::TIMER_CLOCK_PAD_MAP_ADDR);

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sys_sel_reg <= csc_pkg::SYS_SEL_RESET;
            lp_sel_reg <= csc_pkg::LP_SEL_RESET;
            crystal_disable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            sys_sel_reg <= bus_req.wdata[csc_pkg::SYS_SEL_LSB +: 2];
            lp_sel_reg <= bus_req.wdata[csc_pkg::LP_SEL_LSB +: 2];
            crystal_disable_reg <= bus_req.wdata[csc_pkg::XTAL_DIS_BIT];
        end
    end

    // ************************************************************
    // Always-on pad register
    // ************************************************************
    // Only rst or a pad-map write changes it; wake-up never touches it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_reg <= 3'h0;
        end else if (wr_tmr) begin
            hold_reg <= bus_req.wdata[2:0];
        end
    end

    // ************************************************************
    // Crystal enable
    // ************************************************************
    // Driven from the next value of the disable bit, so it drops in the write cycle edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fast_crystal_osc_enable <= 1'b1;
        end else if (wr_ctrl) begin
            fast_crystal_osc_enable <= !bus_req.wdata[csc_pkg::XTAL_DIS_BIT];
        end else if (wakeup_event) begin
            fast_crystal_osc_enable <= !crystal_disable_reg;
        end
    end

    // ************************************************************
    // Glitch-free source switch
    // ************************************************************
    // Gate low, wait, change mux, wait, ungate: no runt pulse on the clock.
    // Selecting the crystal before it settles is left to software.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= CSC_IDLE;
            active_sel_reg <= csc_pkg::SYS_SEL_RESET;
            dwell_reg <= 3'h0;
            system_clock_gate <= 1'b1;
        end else begin
            case (state_reg)
                CSC_IDLE: begin
                    if (sys_sel_reg != active_sel_reg) begin
                        system_clock_gate <= 1'b0;
                        dwell_reg <= csc_pkg::SWITCH_DWELL;
                        state_reg <= CSC_GATE_OFF;
                    end
                end
                CSC_GATE_OFF: begin
                    if (dwell_reg == 3'h0) begin
                        active_sel_reg <= sys_sel_reg;
                        dwell_reg <= csc_pkg::SWITCH_DWELL;
                        state_reg <= CSC_GATE_ON;
                    end else begin
                        dwell_reg <= dwell_reg - 3'h1;
                    end
                end
                CSC_GATE_ON: begin
                    if (dwell_reg == 3'h0) begin
                        system_clock_gate <= 1'b1;
                        state_reg <= CSC_IDLE;
                    end else begin
                        dwell_reg <= dwell_reg - 3'h1;
                    end
                end
                default: state_reg <= CSC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            system_clock_select <= csc_pkg::SYS_SEL_RESET;
            lowpower_clock_select <= csc_pkg::LP_SEL_RESET;
            running_sources <= 4'h2;
            timer1_pwm_pad_hold <= 1'b0;
            timer2_pwm_pad_hold <= 1'b0;
            wakeup_counter_clock_enable <= 1'b0;
        end else begin
            system_clock_select <= active_sel_reg;
            lowpower_clock_select <= lp_sel_reg;
            if (state_reg == CSC_IDLE) begin
                running_sources <= csc_onehot(active_sel_reg);
            end
            timer1_pwm_pad_hold <= hold_reg[csc_pkg::TMR1_HOLD_BIT];
            timer2_pwm_pad_hold <= hold_reg[csc_pkg::TMR2_HOLD_BIT];
            wakeup_counter_clock_enable <= hold_reg[csc_pkg::WAKEUP_EN_BIT];
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= 32'h0;
        end else if (bus_req.rd) begin
            bus_rdata <= 32'h0;
            if (bus_req.addr == csc_pkg::CLOCK_CONTROL_ADDR) begin
                bus_rdata[csc_pkg::SYS_SEL_LSB +: 2] <= sys_sel_reg;
                bus_rdata[csc_pkg::LP_SEL_LSB +: 2] <= lp_sel_reg;
                bus_rdata[csc_pkg::XTAL_DIS_BIT] <= crystal_disable_reg;
                bus_rdata[csc_pkg::RUN_LP_BIT] <= running_sources[0];
                bus_rdata[csc_pkg::RUN_RC_BIT] <= running_sources[1];
                bus_rdata[csc_pkg::RUN_XTAL_BIT] <= running_sources[2];
                bus_rdata[csc_pkg::RUN_DBL_BIT] <= running_sources[3];
            end else if (bus_req.addr == csc_pkg::TIMER_CLOCK_PAD_MAP_ADDR) begin
                bus_rdata[2:0] <= hold_reg;
            end
        end else begin
            bus_rdata <= 32'h0;
        end
    end

endmodule
`default_nettype wire

// file: testbench/csc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module csc_checker (
    // Watched ports
    input wire logic core_clk,
    input wire logic rst,
    input wire csc_pkg::csc_bus_req_t bus_req,
    input wire logic wakeup_event,
    input wire logic fast_crystal_osc_enable,
    input wire logic [1:0] system_clock_select,
    input wire logic [1:0] lowpower_clock_select,
    input wire logic system_clock_gate,
    input wire logic [3:0] running_sources,
    input wire logic timer1_pwm_pad_hold,
    input wire logic timer2_pwm_pad_hold,
    input wire logic wakeup_counter_clock_enable
);
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    localparam logic [15:0] RUN_MAP = 16'h8124;
    logic wc;
    logic wm;
    logic [2:0] pm;
    assign wc = bus_req.wr && bus_req.addr == csc_pkg::CLOCK_CONTROL_ADDR;
    assign wm = bus_req.wr && bus_req.addr == csc_pkg::TIMER_CLOCK_PAD_MAP_ADDR;
    assign pm = {timer2_pwm_pad_hold, timer1_pwm_pad_hold, wakeup_counter_clock_enable};
    // Last written disable bit, so wake-ups are judged against it
    logic dis_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dis_q <= 1'b0;
        end else if (wc) begin
            dis_q <= bus_req.wdata[5];
        end
    end
    a_xtal_off_now: assert property (wc && bus_req.wdata[5] |=> !fast_crystal_osc_enable)
        else $error("crystal still on after disable");
    a_xtal_stays_off: assert property (dis_q && !wc |=> !fast_crystal_osc_enable)
        else $error("crystal came back on");
    a_lp_sel_follow: assert property (wc |=> ##1 lowpower_clock_select == $past(bus_req.wdata[3:2], 2))
        else $error("low-power select wrong");
    a_pad_map_write: assert property (wm |=> ##1 pm == $past(bus_req.wdata[2:0], 2))
        else $error("pad map wrong");
    a_pad_map_hold: assert property (!wm && !$past(wm) |=> $stable(pm))
        else $error("pad map lost");
    a_gate_on_switch: assert property (wc && system_clock_gate && bus_req.wdata[1:0] != system_clock_select
        |=> ##1 !system_clock_gate [*8] ##1 system_clock_gate)
        else $error("switch gating wrong");
    a_sel_gated: assert property ($changed(system_clock_select) |-> !system_clock_gate)
        else $error("select changed ungated");
    a_running_match: assert property (system_clock_gate && $past(system_clock_gate)
        |-> running_sources == RUN_MAP[{system_clock_select, 2'b00} +: 4])
        else $error("running indicator wrong");
    c_disable: cover property (wc && bus_req.wdata[5]);
    c_switch: cover property ($changed(system_clock_select));
    c_pad: cover property (wm && bus_req.wdata[2]);
endmodule
bind csc_clock_source_select_ctrl csc_checker u_chk (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .wakeup_event(wakeup_event),
    .fast_crystal_osc_enable(fast_crystal_osc_enable), .system_clock_select(system_clock_select),
    .lowpower_clock_select(lowpower_clock_select), .system_clock_gate(system_clock_gate),
    .running_sources(running_sources), .timer1_pwm_pad_hold(timer1_pwm_pad_hold),
    .timer2_pwm_pad_hold(timer2_pwm_pad_hold), .wakeup_counter_clock_enable(wakeup_counter_clock_enable));
`default_nettype wire

// file: testbench/tb_clock_source_select_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_clock_source_select_ctrl;
    // ************************************************************
    // Bench
    // ************************************************************
    logic core_clk, rst, wakeup_event, xen, gate, t1, t2, wen;
    csc_pkg::csc_bus_req_t bus_req;
    logic [31:0] bus_rdata;
    logic [1:0] sel, lp;
    logic [3:0] run;
    int err_total, n_compared;
    localparam logic [31:0] CA = csc_pkg::CLOCK_CONTROL_ADDR;
    localparam logic [31:0] PA = csc_pkg::TIMER_CLOCK_PAD_MAP_ADDR;
    localparam logic [15:0] RUN_MAP = 16'h8124;
    csc_clock_source_select_ctrl dut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .crystal_settled(1'b1), .crystal_trim_ready(1'b1), .wakeup_event(wakeup_event),
        .fast_crystal_osc_enable(xen), .system_clock_select(sel), .lowpower_clock_select(lp),
        .system_clock_gate(gate), .running_sources(run), .timer1_pwm_pad_hold(t1),
        .timer2_pwm_pad_hold(t2), .wakeup_counter_clock_enable(wen));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        // Low-power select and pad outputs follow the registers one edge later
        @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask
    task automatic wake();
        @(posedge core_clk);
        wakeup_event <= 1'b1;
        @(posedge core_clk);
        wakeup_event <= 1'b0;
        #1;
    endtask
    task automatic t_reset();
        chk({xen, gate, sel, lp, run}, {1'b1, 1'b1, 2'h1, 2'h0, 4'h2});
        rd(CA, 32'h2001);
        rd(32'h5000_001C, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_lp();
        for (int v = 0; v < 4; v++) begin
            wr(CA, {28'h0, v[1:0], 2'h1});
            chk(lp, v[1:0]);
        end
        rd(CA, 32'h200D);
        $display("low-power select test done");
    endtask
    task automatic t_sys();
        logic [1:0] s [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
        foreach (s[k]) begin
            wr(CA, {30'h0, s[k]});
            // Bounded wait: a stuck gate must not hang the run
            for (int i = 0; gate !== 1'b0; i++) begin
                if (i == 40) begin
                    err_total++;
                    close_out();
                end
                @(posedge core_clk);
            end
            for (int i = 0; gate !== 1'b1; i++) begin
                if (i == 40) begin
                    err_total++;
                    close_out();
                end
                @(posedge core_clk);
            end
            repeat (2) @(posedge core_clk);
            #1 chk({sel, run}, {s[k], RUN_MAP[{s[k], 2'b00} +: 4]});
            rd(CA, {16'h0, RUN_MAP[{s[k], 2'b00} +: 4], 10'h0, s[k]});
        end
        $display("system select test done");
    endtask
    task automatic t_xtal();
        wr(CA, 32'h21);
        chk(xen, 1'b0);
        wake();
        chk(xen, 1'b0);
        wr(CA, 32'h01);
        wake();
        chk(xen, 1'b1);
        $display("crystal disable test done");
    endtask
    task automatic t_pad();
        wr(PA, 32'h6);
        chk({t2, t1, wen}, 3'h6);
        wake();
        wr(32'h5000_001C, 32'h1);
        rd(PA, 32'h6);
        wr(PA, 32'h1);
        chk({t2, t1, wen}, 3'h1);
        $display("pad map test done");
    endtask
    initial begin
        rst = 1'b1;
        wakeup_event = 1'b0;
        bus_req = '0;
        err_total = 0;
        n_compared = 0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_lp();
        t_sys();
        t_xtal();
        t_pad();
        close_out();
    end
endmodule
`default_nettype wire
